// >>> verilog/twr_consts.svh
// Timing constants for the repeater-side bus controller
`ifndef TWR_CONSTS_SVH
`define TWR_CONSTS_SVH

// System clock period, ns
`define TWR_CLK_NS      5
// Least half period of the serial clock at the 400 kHz ceiling, ns
`define TWR_HALF_NS     1250
// Least time from enable to a start condition, ns
`define TWR_SET_NS      100
// Least times rounded up to whole system clock cycles
`define TWR_HALF_CYC    ((`TWR_HALF_NS + `TWR_CLK_NS - 1) / `TWR_CLK_NS)
`define TWR_SET_CYC     ((`TWR_SET_NS + `TWR_CLK_NS - 1) / `TWR_CLK_NS)
// Data moves this fraction of the way into the clock low phase
`define TWR_DATA_DIV    2
// Bits per byte frame, acknowledge included
`define TWR_FRAME_BITS  9
// Reset values
`define TWR_EN_RST      1'b0
`define TWR_LINE_LOW    1'b0

`endif

// >>> verilog/twr_pkg.sv
// Types shared by the repeater-side bus controller
package twr_pkg;

    typedef enum logic [1:0] {
        TWR_CMD_START = 2'h0,
        TWR_CMD_WRITE = 2'h1,
        TWR_CMD_READ  = 2'h2,
        TWR_CMD_STOP  = 2'h3
    } twr_cmd_t;

    typedef enum logic [2:0] {
        TWR_S_IDLE  = 3'h0,
        TWR_S_START = 3'h1,
        TWR_S_HOLD  = 3'h3,
        TWR_S_BLOW  = 3'h2,
        TWR_S_BHIGH = 3'h6,
        TWR_S_STOPA = 3'h7,
        TWR_S_STOPB = 3'h5,
        TWR_S_RSTA  = 3'h4
    } twr_state_t;

endpackage

// >>> verilog/twr_sync.sv
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module twr_sync #(
    parameter int W = 2
) (
    input  wire logic         clk,
    input  wire logic         nrst,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    logic [W-1:0] meta_q;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            meta_q <= {W{1'b1}};
            q      <= {W{1'b1}};
        end else begin
            meta_q <= d;
            q      <= meta_q;
        end
    end

endmodule

// >>> verilog/twr_ctrl.sv
// Bus controller and enable manager facing a two-wire bus repeater
`timescale 1ns/1ps
`include "twr_consts.svh"
module twr_ctrl #(
    parameter int HALF_CYC = `TWR_HALF_CYC,
    parameter int SET_CYC  = `TWR_SET_CYC
) (
    input  wire logic             CLOCK,
    input  wire logic             NRST,
    input  wire logic             REQ_EN,
    input  wire logic             CMD_VALID,
    input  wire twr_pkg::twr_cmd_t CMD,
    input  wire logic [7:0]       CMD_DATA,
    input  wire logic             CMD_NACK,
    output logic                  READY,
    output logic                  DONE,
    output logic                  STAT_ERR,
    output logic                  STAT_LOST,
    output logic [7:0]            RD_DATA,
    output logic                  ACK_RX,
    output logic                  BUS_BUSY,
    output logic                  REPEATER_EN,
    input  wire logic             CLOCK_LINE_I,
    output logic                  CLOCK_LINE_O,
    output logic                  CLOCK_LINE_OE,
    input  wire logic             DATA_LINE_I,
    output logic                  DATA_LINE_O,
    output logic                  DATA_LINE_OE
);
    import twr_pkg::*;

    localparam logic [8:0] HALF_M1 = 9'(HALF_CYC - 1);
    localparam logic [7:0] SET_MAX = 8'(SET_CYC);
    localparam logic [3:0] LAST_BIT = 4'(`TWR_FRAME_BITS - 1);
    localparam logic [8:0] DATA_AT = 9'(HALF_CYC / `TWR_DATA_DIV);

    logic       scl_s;
    logic       sda_s;
    logic       scl_p_q;
    logic       sda_p_q;
    logic       busy_q;
    logic       en_q;
    logic [7:0] set_cnt_q;
    logic       settled;
    logic       ready_q;
    logic       accept;
    twr_state_t state_q;
    logic       phase_q;
    logic [8:0] cnt_q;
    logic [3:0] bit_q;
    logic [8:0] tx_q;
    logic [8:0] own_q;
    logic [8:0] rx_q;
    logic       scl_oe_q;
    logic       sda_oe_q;
    logic       zero_q;
    logic       done_q;
    logic       err_q;
    logic       lost_q;
    logic [7:0] rd_q;
    logic       ack_q;
    logic       wait_high;
    logic       half_done;
    logic       lose;
    logic [8:0] rx_d;

    ////////////////////////////////////////////////////////////////////
    // Pin sampling and bus activity

    twr_sync #(
        .W (2)
    ) u_sync (
        .clk  (CLOCK),
        .nrst (NRST),
        .d    ({CLOCK_LINE_I, DATA_LINE_I}),
        .q    ({scl_s, sda_s})
    );

    always_ff @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            scl_p_q <= 1'b1;
            sda_p_q <= 1'b1;
        end else begin
            scl_p_q <= scl_s;
            sda_p_q <= sda_s;
        end
    end

    // Start sets busy, stop clears it; start wins
    always_ff @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            busy_q <= 1'b0;
        end else if (scl_s && scl_p_q && sda_p_q && !sda_s) begin
            busy_q <= 1'b1;
        end else if (scl_s && scl_p_q && !sda_p_q && sda_s) begin
            busy_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Repeater enable and start setup time

    always_ff @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            en_q <= `TWR_EN_RST;
        end else if (state_q == TWR_S_IDLE && !busy_q && !CMD_VALID) begin
            en_q <= REQ_EN;
        end
    end

    always_ff @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            set_cnt_q <= 8'h00;
        end else if (!en_q) begin
            set_cnt_q <= 8'h00;
        end else if (set_cnt_q != SET_MAX) begin
            set_cnt_q <= set_cnt_q + 8'h01;
        end
    end

    assign settled = en_q && (set_cnt_q == SET_MAX);

    ////////////////////////////////////////////////////////////////////
    // Command handshake

    assign accept = CMD_VALID && ready_q;

    always_ff @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            ready_q <= 1'b0;
        end else if (accept) begin
            ready_q <= 1'b0;
        end else if (state_q == TWR_S_IDLE) begin
            ready_q <= settled && !busy_q && (REQ_EN == en_q);
        end else begin
            ready_q <= (state_q == TWR_S_HOLD);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Bit engine

    // Clock stretching: high time counts only once the line is high
    assign wait_high = (state_q == TWR_S_BHIGH)
                    || (state_q == TWR_S_RSTA && phase_q)
                    || (state_q == TWR_S_STOPB && !phase_q);
    assign half_done = (cnt_q == HALF_M1) && !(wait_high && !scl_s);
    assign lose      = (state_q == TWR_S_BHIGH) && scl_s && own_q[8]
                    && tx_q[8] && !sda_s;
    assign rx_d      = {rx_q[7:0], sda_s};

    always_ff @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            cnt_q <= 9'h000;
        end else if (state_q == TWR_S_IDLE || state_q == TWR_S_HOLD
                     || half_done || lose) begin
            cnt_q <= 9'h000;
        end else if (!(wait_high && !scl_s)) begin
            cnt_q <= cnt_q + 9'h001;
        end
    end

    always_ff @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            state_q  <= TWR_S_IDLE;
            phase_q  <= 1'b0;
            bit_q    <= 4'h0;
            tx_q     <= 9'h1ff;
            own_q    <= 9'h000;
            rx_q     <= 9'h000;
            scl_oe_q <= 1'b0;
            sda_oe_q <= 1'b0;
            done_q   <= 1'b0;
            err_q    <= 1'b0;
            lost_q   <= 1'b0;
            rd_q     <= 8'h00;
            ack_q    <= 1'b0;
        end else begin
            done_q <= 1'b0;
            unique case (state_q)
                TWR_S_IDLE: begin
                    scl_oe_q <= 1'b0;
                    sda_oe_q <= 1'b0;
                    if (accept && CMD == TWR_CMD_START) begin
                        state_q  <= TWR_S_START;
                        sda_oe_q <= 1'b1;
                    end else if (accept) begin
                        done_q <= 1'b1;
                        err_q  <= 1'b1;
                        lost_q <= 1'b0;
                    end
                end
                TWR_S_START: begin
                    if (half_done) begin
                        scl_oe_q <= 1'b1;
                        state_q  <= TWR_S_HOLD;
                        done_q   <= 1'b1;
                        err_q    <= 1'b0;
                        lost_q   <= 1'b0;
                    end
                end
                TWR_S_HOLD: begin
                    if (accept) begin
                        bit_q   <= 4'h0;
                        phase_q <= 1'b0;
                        unique case (CMD)
                            TWR_CMD_START: begin
                                state_q  <= TWR_S_RSTA;
                                sda_oe_q <= 1'b0;
                            end
                            TWR_CMD_WRITE: begin
                                state_q  <= TWR_S_BLOW;
                                tx_q     <= {CMD_DATA, 1'b1};
                                own_q    <= 9'h1fe;
                            end
                            TWR_CMD_READ: begin
                                state_q  <= TWR_S_BLOW;
                                tx_q     <= {8'hff, CMD_NACK};
                                own_q    <= 9'h001;
                            end
                            TWR_CMD_STOP: begin
                                state_q  <= TWR_S_STOPA;
                                sda_oe_q <= 1'b1;
                            end
                        endcase
                    end
                end
                TWR_S_BLOW: begin
                    // Data moves mid-low, well after the far clock fell
                    if (cnt_q == DATA_AT) begin
                        sda_oe_q <= !tx_q[8];
                    end
                    if (half_done) begin
                        scl_oe_q <= 1'b0;
                        state_q  <= TWR_S_BHIGH;
                    end
                end
                TWR_S_BHIGH: begin
                    if (lose) begin
                        // Arbitration lost: let go of both lines
                        scl_oe_q <= 1'b0;
                        sda_oe_q <= 1'b0;
                        state_q  <= TWR_S_IDLE;
                        done_q   <= 1'b1;
                        err_q    <= 1'b0;
                        lost_q   <= 1'b1;
                    end else if (half_done) begin
                        rx_q     <= rx_d;
                        tx_q     <= {tx_q[7:0], 1'b1};
                        own_q    <= {own_q[7:0], 1'b0};
                        scl_oe_q <= 1'b1;
                        bit_q    <= bit_q + 4'h1;
                        if (bit_q == LAST_BIT) begin
                            state_q <= TWR_S_HOLD;
                            done_q  <= 1'b1;
                            err_q   <= 1'b0;
                            lost_q  <= 1'b0;
                            rd_q    <= rx_d[8:1];
                            ack_q   <= !rx_d[0];
                        end else begin
                            state_q  <= TWR_S_BLOW;
                        end
                    end
                end
                TWR_S_RSTA: begin
                    if (half_done && !phase_q) begin
                        phase_q  <= 1'b1;
                        scl_oe_q <= 1'b0;
                    end else if (half_done) begin
                        phase_q  <= 1'b0;
                        sda_oe_q <= 1'b1;
                        state_q  <= TWR_S_START;
                    end
                end
                TWR_S_STOPA: begin
                    if (half_done) begin
                        scl_oe_q <= 1'b0;
                        phase_q  <= 1'b0;
                        state_q  <= TWR_S_STOPB;
                    end
                end
                TWR_S_STOPB: begin
                    if (half_done && !phase_q) begin
                        phase_q  <= 1'b1;
                        sda_oe_q <= 1'b0;
                    end else if (half_done) begin
                        phase_q <= 1'b0;
                        state_q <= TWR_S_IDLE;
                        done_q  <= 1'b1;
                        err_q   <= 1'b0;
                        lost_q  <= 1'b0;
                    end
                end
                default: begin
                    state_q <= TWR_S_IDLE;
                end
            endcase
        end
    end

    // Open-drain: the driven level is always low
    always_ff @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            zero_q <= `TWR_LINE_LOW;
        end else begin
            zero_q <= `TWR_LINE_LOW;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Outputs

    assign READY         = ready_q;
    assign DONE          = done_q;
    assign STAT_ERR      = err_q;
    assign STAT_LOST     = lost_q;
    assign RD_DATA       = rd_q;
    assign ACK_RX        = ack_q;
    assign BUS_BUSY      = busy_q;
    assign REPEATER_EN   = en_q;
    assign CLOCK_LINE_O  = zero_q;
    assign CLOCK_LINE_OE = scl_oe_q;
    assign DATA_LINE_O   = zero_q;
    assign DATA_LINE_OE  = sda_oe_q;

    ////////////////////////////////////////////////////////////////////
    // Checks

    logic [8:0] low_cnt_q;

    always_ff @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            low_cnt_q <= 9'h000;
        end else if (!scl_oe_q) begin
            low_cnt_q <= 9'h000;
        end else if (low_cnt_q != 9'h1ff) begin
            low_cnt_q <= low_cnt_q + 9'h001;
        end
    end

    sequence idle_start_s;
        state_q == TWR_S_IDLE && accept && CMD == TWR_CMD_START;
    endsequence

    enable_when_idle_a: assert property (
        @(posedge CLOCK) disable iff (!NRST)
        $changed(en_q) |-> $past(state_q == TWR_S_IDLE && !busy_q))
        else $error("enable changed while bus active");

    enable_before_start_a: assert property (
        @(posedge CLOCK) disable iff (!NRST)
        idle_start_s |-> en_q && set_cnt_q == SET_MAX)
        else $error("start too soon after enable");

    drive_low_only_a: assert property (
        @(posedge CLOCK) disable iff (!NRST)
        !CLOCK_LINE_O && !DATA_LINE_O)
        else $error("line driven high");

    clock_low_min_a: assert property (
        @(posedge CLOCK) disable iff (!NRST)
        $fell(scl_oe_q) |-> $past(low_cnt_q) >= HALF_M1)
        else $error("clock low phase too short");

    lost_releases_lines_a: assert property (
        @(posedge CLOCK) disable iff (!NRST)
        lose |=> !scl_oe_q && !sda_oe_q && lost_q && done_q)
        else $error("arbitration loss kept driving");

    start_leads_clock_a: assert property (
        @(posedge CLOCK) disable iff (!NRST)
        idle_start_s |=> sda_oe_q && !scl_oe_q)
        else $error("start did not lower data first");

    stretch_holds_a: assert property (
        @(posedge CLOCK) disable iff (!NRST)
        state_q == TWR_S_BHIGH && !scl_s && !lose |=> $stable(cnt_q))
        else $error("high phase counted while stretched");

endmodule

// >>> verification/twr_rptr_model.sv
// Behavioural model of the two-channel two-wire bus repeater
`timescale 1ns/1ps
module twr_rptr_model #(
    parameter int DLY_NS = 57
) (
    input  wire logic       en,
    input  wire logic [1:0] ext0_low,
    input  wire logic [1:0] ext1_low,
    output logic      [1:0] drv0_low,
    output logic      [1:0] drv1_low
);
    logic en_eff;

    // Floating enable reads high; low enable isolates the sides
    assign en_eff = (en !== 1'b0);
    // Bit 0 clock, bit 1 data, same non-inverting channel each way
    // Only outside lows are inputs, own lows never echo back
    // Outside low copied across, release follows release
    // Two-sided low leaves nothing latched once both let go
    assign #(DLY_NS) drv1_low = ext0_low & {2{en_eff}};
    assign #(DLY_NS) drv0_low = ext1_low & {2{en_eff}};
endmodule

// >>> verification/two_wire_bus_repeater_test.sv
// Self-checking bench for the repeater-side bus controller
`timescale 1ns/1ps
module two_wire_bus_repeater_test;
    import twr_pkg::*;
    localparam int         HALF = 40;
    localparam int         SET  = 20;
    localparam logic [6:0] ADDR = 7'h2a;
    logic       clk, nrst, req_en, cmd_valid, cmd_nack;
    twr_cmd_t   cmd;
    logic [7:0] cmd_data, rd_data, d, t_sr, t_rx, t_tx;
    logic [6:0] a;
    logic [3:0] t_bit;
    logic       ready, done, stat_err, stat_lost, ack_rx, bus_busy, rep_en;
    logic       scl_o, scl_oe, sda_o, sda_oe, match, en_last, busy_last;
    logic       t_scl, t_sda, rog, t_first, t_sel, t_rd, t_nack;
    logic [1:0] drv0, drv1;
    wire        bus0_clock_line, bus0_data_line, bus1_clock_line, bus1_data_line;
    int         errors, checked, stretch, k, j, n, nb;
    realtime    t_rise, t_fall;

    // Lines sit high through pull-ups unless someone pulls low
    assign bus0_clock_line = ~((scl_oe & ~scl_o) | drv0[0]);
    assign bus0_data_line = ~((sda_oe & ~sda_o) | drv0[1]);
    assign bus1_clock_line = ~(drv1[0] | t_scl);
    assign bus1_data_line = ~(drv1[1] | t_sda | rog);

    twr_ctrl #(.HALF_CYC(HALF), .SET_CYC(SET)) uut (
        .CLOCK         (clk),
        .NRST          (nrst),
        .REQ_EN        (req_en),
        .CMD_VALID     (cmd_valid),
        .CMD           (cmd),
        .CMD_DATA      (cmd_data),
        .CMD_NACK      (cmd_nack),
        .READY         (ready),
        .DONE          (done),
        .STAT_ERR      (stat_err),
        .STAT_LOST     (stat_lost),
        .RD_DATA       (rd_data),
        .ACK_RX        (ack_rx),
        .BUS_BUSY      (bus_busy),
        .REPEATER_EN   (rep_en),
        .CLOCK_LINE_I  (bus0_clock_line),
        .CLOCK_LINE_O  (scl_o),
        .CLOCK_LINE_OE (scl_oe),
        .DATA_LINE_I   (bus0_data_line),
        .DATA_LINE_O   (sda_o),
        .DATA_LINE_OE  (sda_oe)
    );

    twr_rptr_model #(.DLY_NS(57)) rptr (
        .en       (rep_en),
        .ext0_low ({sda_oe & ~sda_o, scl_oe & ~scl_o}),
        .ext1_low ({t_sda | rog, t_scl}),
        .drv0_low (drv0),
        .drv1_low (drv1)
    );

    ////////////////////////////////////////////////////////////////////////
    // Target on bus 1: acks its address, stores writes, serves reads
    always @(negedge bus1_data_line) begin
        if (bus1_clock_line) begin
            t_bit = 0;
            t_first = 1;
            t_nack = 0;
        end
    end
    always @(posedge bus1_clock_line) begin
        if (t_bit < 8) t_sr = {t_sr[6:0], bus1_data_line};
        else t_nack = bus1_data_line;
        t_bit = t_bit + 1;
    end
    always @(negedge bus1_clock_line) begin
        if (t_bit == 8) begin
            if (t_first) begin
                t_sel = (t_sr[7:1] == ADDR);
                t_rd = t_sr[0];
            end else if (t_sel && !t_rd) t_rx = t_sr;
            t_sda = t_sel && !(t_rd && !t_first);
        end else if (t_bit == 9) begin
            t_bit = 0;
            t_first = 0;
            t_sda = t_sel && t_rd && !t_nack && !t_tx[7];
            // Clock stretch carried back across the repeater
            t_scl = 1;
            #(stretch) t_scl = 0;
        end else
            t_sda = t_sel && t_rd && !t_first && !t_nack && !t_tx[7 - t_bit];
    end

    ////////////////////////////////////////////////////////////////////////
    // Monitors on bus 0
    always @(posedge clk) begin
        if (busy_last === 1'b1) check("en_busy", rep_en, en_last);
        busy_last = bus_busy;
        en_last = rep_en;
    end
    always @(posedge bus0_clock_line) begin
        t_rise = $realtime;
        if (bus_busy === 1'b1)
            check("low_t", ($realtime - t_fall) >= HALF * 5.0, 1);
    end
    always @(negedge bus0_clock_line) begin
        t_fall = $realtime;
        if (bus_busy === 1'b1)
            check("high_t", ($realtime - t_rise) >= HALF * 5.0, 1);
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic check(string name, logic [7:0] seen, logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic results();
        $display("errors %0d checked %0d", errors, checked);
        if (errors == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic wait_for(ref logic sig, input logic val);
        int i;
        for (i = 0; i < 20000 && sig !== val; i++)
            @(posedge clk);
        if (sig !== val) begin
            check("wait", sig, val);
            results();
        end
    endtask

    task automatic do_cmd(twr_cmd_t c, logic [7:0] dv, logic nk);
        cmd_valid <= 1'b1;
        cmd <= c;
        cmd_data <= dv;
        cmd_nack <= nk;
        @(posedge clk);
        wait_for(ready, 1'b1);
        cmd_valid <= 1'b0;
        wait_for(done, 1'b1);
    endtask

    task automatic xfer(logic [7:0] dv, logic ack_exp);
        do_cmd(TWR_CMD_WRITE, dv, 1'b0);
        check("ack", ack_rx, ack_exp);
        check("lost", stat_lost, 0);
    endtask

    function automatic logic [7:0] addr_byte(logic [6:0] ad, logic rd);
        return {ad, rd};
    endfunction

    ////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 0;
        forever #2.5 clk = ~clk;
    end

    initial begin
        nrst = 0; req_en = 0; cmd_valid = 0; cmd = TWR_CMD_START;
        cmd_data = 0; cmd_nack = 0; t_scl = 0; t_sda = 0; rog = 0;
        t_bit = 0; t_first = 0; t_sel = 0; t_nack = 0; t_rx = 0; t_tx = 0;
        errors = 0; checked = 0; stretch = 0; busy_last = 0;
        t_rise = 0; t_fall = 0;
        void'($urandom(71492));
        repeat (8) @(posedge clk);
        check("en_rst", rep_en, 0);
        check("oe_rst", {scl_oe, sda_oe, ready}, 0);
        nrst <= 1'b1;
        @(posedge clk);
        req_en <= 1'b1;
        wait_for(rep_en, 1'b1);
        for (n = 0; n < 1000 && ready !== 1'b1; n++)
            @(posedge clk);
        check("setup", 8'(n), 8'(SET + 1));
        if (ready !== 1'b1) results();
        do_cmd(TWR_CMD_WRITE, 8'h00, 1'b0);
        check("err", stat_err, 1);
        // Enable drop requested mid-transfer, held off until the stop
        do_cmd(TWR_CMD_START, 8'h00, 1'b0);
        req_en <= 1'b0;
        xfer(addr_byte(ADDR, 1'b0), 1'b1);
        do_cmd(TWR_CMD_STOP, 8'h00, 1'b0);
        wait_for(rep_en, 1'b0);
        // Isolated: start withheld, a bus 1 low never reaches bus 0
        rog <= 1'b1;
        repeat (40) @(posedge clk);
        check("iso_rdy", ready, 0);
        check("iso_sda", bus0_data_line, 1);
        rog <= 1'b0;
        repeat (40) @(posedge clk);
        req_en <= 1'b1;
        wait_for(rep_en, 1'b1);
        // Another master on bus 1 wins arbitration, then stops
        do_cmd(TWR_CMD_START, 8'h00, 1'b0);
        xfer(addr_byte(ADDR, 1'b0), 1'b1);
        fork
            do_cmd(TWR_CMD_WRITE, 8'hff, 1'b0);
            begin
                for (n = 0; n < 2000 && bus1_clock_line !== 1'b0; n++)
                    @(posedge clk);
                if (bus1_clock_line !== 1'b0) begin
                    check("bus1_clock_line_lo", bus1_clock_line, 0);
                    results();
                end
                rog <= 1'b1;
            end
        join
        check("lost", stat_lost, 1);
        for (n = 0; n < 2000 && bus1_clock_line !== 1'b1; n++)
            @(posedge clk);
        if (bus1_clock_line !== 1'b1) begin
            check("bus1_clock_line_hi", bus1_clock_line, 1);
            results();
        end
        rog <= 1'b0;
        wait_for(bus_busy, 1'b0);
        // Random traffic, one wrong address among it
        for (k = 0; k < 6; k++) begin
            match = (k != 2);
            a = match ? ADDR : ADDR ^ 7'h01;
            stretch = $urandom_range(0, 255);
            nb = $urandom_range(1, 3);
            do_cmd(TWR_CMD_START, 8'h00, 1'b0);
            xfer(addr_byte(a, 1'b0), match);
            for (j = 0; j < nb; j++) begin
                d = 8'($urandom);
                xfer(d, match);
                if (match) check("rx", t_rx, d);
            end
            if (match) begin
                t_tx = 8'($urandom);
                do_cmd(TWR_CMD_START, 8'h00, 1'b0);
                xfer(addr_byte(a, 1'b1), 1'b1);
                do_cmd(TWR_CMD_READ, 8'h00, 1'b0);
                check("rd0", rd_data, t_tx);
                check("rdack0", ack_rx, 1);
                do_cmd(TWR_CMD_READ, 8'h00, 1'b1);
                check("rd1", rd_data, t_tx);
                check("rdack1", ack_rx, 0);
            end
            do_cmd(TWR_CMD_STOP, 8'h00, 1'b0);
            wait_for(bus_busy, 1'b0);
            check("idle", {bus0_clock_line, bus0_data_line, bus1_clock_line, bus1_data_line}, 8'h0f);
        end
        results();
    end
endmodule
